// ===== pkg/hbbrk_pkg.sv
package hbbrk_pkg;
  localparam int HBBRK_CLK_HZ = 20000000;
  localparam int HBBRK_NUM_BRIDGES = 4;
  localparam logic [1:0] HBBRK_MODE_OFF = 2'h0;
  localparam logic [1:0] HBBRK_MODE_LS_PWM = 2'h1;
  localparam logic [1:0] HBBRK_MODE_HS_PWM = 2'h2;
  localparam logic [2:0] HBBRK_OPM_INIT = 3'h0;
  localparam logic [2:0] HBBRK_OPM_NORMAL = 3'h1;
  localparam logic [2:0] HBBRK_OPM_STOP = 3'h2;
  localparam logic [2:0] HBBRK_OPM_SLEEP = 3'h3;
  localparam logic [2:0] HBBRK_OPM_FAILSAFE = 3'h4;
  localparam logic [2:0] HBBRK_OPM_RESTART = 3'h5;
  localparam logic HBBRK_MOSFET_LEVEL_SELECT_RST = 1'b0;
  localparam logic HBBRK_AUTO_STAGE_RST = 1'b0;
  localparam logic HBBRK_FMOD_RST = 1'b1;
  localparam int HBBRK_FMOD_HZ10 = 156000;
  localparam int HBBRK_FMOD_HALF_CYC = HBBRK_CLK_HZ * 10 / HBBRK_FMOD_HZ10 / 2;
  localparam int HBBRK_CCP_W = 8;
  localparam int HBBRK_BRAKE_TON_NS = 100;
  localparam int HBBRK_BRAKE_TON_CYC =
    (HBBRK_BRAKE_TON_NS * 20 + 999) / 1000;
  localparam int HBBRK_PUMP_OFF_NS = 100;
  localparam int HBBRK_PUMP_OFF_CYC =
    (HBBRK_PUMP_OFF_NS * 20 + 999) / 1000;
  typedef enum logic [4:0] {
    HBBRK_ST_IDLE = 5'h01,
    HBBRK_ST_ACTOFF = 5'h02,
    HBBRK_ST_PUMPOFF = 5'h04,
    HBBRK_ST_SLAM = 5'h08,
    HBBRK_ST_PARK = 5'h10
  } hbbrk_state_t;
  function automatic logic hbbrk_is_active(input logic [1:0] m);
    return (m == HBBRK_MODE_LS_PWM) || (m == HBBRK_MODE_HS_PWM);
  endfunction : hbbrk_is_active
endpackage : hbbrk_pkg

// ===== design/hbbrk_ccp_timer.sv
`timescale 1ns/10ps
module hbbrk_ccp_timer
  import hbbrk_pkg::*;
(
  input wire logic ref_clk, // Clock.
  input wire logic sys_rst, // Synchronous reset.
  input wire logic start, // Start pulse.
  input wire logic [HBBRK_CCP_W-1:0] ccp_time, // Time in cycles.
  output logic busy // Counting.
);
  logic [HBBRK_CCP_W-1:0] cnt;
  logic [HBBRK_CCP_W-1:0] next_cnt;

  always_comb begin
    next_cnt = cnt;
    if (start) begin
      next_cnt = (ccp_time == '0) ? HBBRK_CCP_W'(1) : ccp_time;
    end else if (cnt != '0) begin
      next_cnt = cnt - HBBRK_CCP_W'(1);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cnt <= '0;
    end else begin
      cnt <= next_cnt;
    end
  end

  assign busy = (cnt != '0);
endmodule : hbbrk_ccp_timer

// ===== design/hbbrk_sequencer.sv
`timescale 1ns/10ps
module hbbrk_sequencer
  import hbbrk_pkg::*;
(
  input wire logic ref_clk, // 20 MHz clock.
  input wire logic sys_rst, // Synchronous reset, active high.
  input wire logic [2:0] op_mode, // Device operating mode.
  input wire logic slam_request, // Slam brake request bit.
  input wire logic parking_brake_enable, // Parking brake enable bit.
  input wire logic [7:0] bridge_mode_field, // Two bits per bridge.
  input wire logic [31:0] cross_current_protect_time, // Cycles per bridge.
  input wire logic [3:0] slam_ls_disable, // Per low-side slam disable.
  input wire logic pump_enable_bit, // Charge pump enable.
  input wire logic pwm_one_input, // External PWM1 pin.
  input wire logic [3:0] hs_normal, // Normal-mode high-side gate request.
  input wire logic [3:0] ls_normal, // Normal-mode low-side gate request.
  input wire logic mosfet_level_select, // 0 logic, 1 normal level.
  input wire logic pump_auto_stage_select, // Automatic stage switching.
  input wire logic pump_freq_mod_enable, // Frequency modulation enable.
  input wire logic supply_above_threshold, // Supply above stage threshold.
  output logic [3:0] hs_gate_on, // High-side gate drive.
  output logic [3:0] ls_gate_on, // Low-side gate drive.
  output logic [3:0] active_off, // Active static discharge.
  output logic [3:0] hs_passive_dis, // High-side passive discharge.
  output logic [3:0] ls_passive_dis, // Low-side passive discharge.
  output logic pump_on, // Charge pump running.
  output logic pump_normal_level, // Pump regulation target.
  output logic pump_single_stage, // Single-stage operation.
  output logic pump_fmod_clk, // Modulation square wave.
  output logic brake_active // Slam or park braking engaged.
);
  hbbrk_state_t state;
  hbbrk_state_t next_state;
  logic [3:0] hs_gate_on_q, ls_gate_on_q, act_q, hsp_q, lsp_q;
  logic [3:0] next_hs, next_ls, next_act, next_hsp, next_lsp;
  logic pump_q, lvl_q, stg_q, fclk_q, brk_q;
  logic next_pump, next_lvl, next_stg, next_fclk, next_brk;
  logic [15:0] fcnt;
  logic [15:0] next_fcnt;
  logic [3:0] pcnt;
  logic [3:0] next_pcnt;
  logic [3:0] tmr_busy;
  logic [3:0] tmr_start;
  logic park_req, slam_ok, in_normal;

  default clocking cb_main @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  assign in_normal = (op_mode == HBBRK_OPM_NORMAL);
  assign slam_ok = in_normal && slam_request;
  assign park_req = parking_brake_enable &&
    (op_mode == HBBRK_OPM_SLEEP || op_mode == HBBRK_OPM_STOP);

  genvar g;
  generate
    for (g = 0; g < HBBRK_NUM_BRIDGES; g++) begin : g_ccp
      assign tmr_start[g] = (state == HBBRK_ST_IDLE) &&
        (slam_ok || park_req) &&
        hbbrk_is_active(bridge_mode_field[2*g+:2]);
      hbbrk_ccp_timer u_tmr (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .start(tmr_start[g]),
        .ccp_time(cross_current_protect_time[8*g+:8]),
        .busy(tmr_busy[g])
      );
    end
  endgenerate

  always_comb begin
    next_state = state;
    next_pcnt = '0;
    next_act = '0;
    next_hs = '0;
    next_ls = '0;
    next_hsp = 4'hf;
    next_lsp = 4'hf;
    next_pump = 1'b0;
    next_brk = 1'b1;
    unique case (state)
      HBBRK_ST_IDLE: begin
        next_brk = 1'b0;
        if (slam_ok || park_req) begin
          next_state = HBBRK_ST_ACTOFF;
          next_act = tmr_start;
          next_pump = pump_enable_bit;
        end else if (in_normal) begin
          next_hs = hs_normal;
          next_ls = ls_normal;
          next_pump = pump_enable_bit;
          next_hsp = pump_enable_bit ? 4'h0 : 4'hf;
          next_lsp = next_hsp;
        end
      end
      HBBRK_ST_ACTOFF: begin
        next_act = tmr_busy;
        next_pump = pump_enable_bit;
        if (tmr_busy == '0) begin
          next_state = HBBRK_ST_PUMPOFF;
          next_act = '0;
          next_pump = 1'b0;
        end
      end
      HBBRK_ST_PUMPOFF: begin
        next_pcnt = pcnt + 4'h1;
        if (pcnt >= 4'(HBBRK_PUMP_OFF_CYC - 1)) begin
          next_state = slam_ok ? HBBRK_ST_SLAM :
            (park_req ? HBBRK_ST_PARK : HBBRK_ST_IDLE);
          next_pcnt = '0;
        end
        if (!slam_ok && !park_req) begin
          next_state = HBBRK_ST_IDLE;
        end
      end
      HBBRK_ST_SLAM: begin
        next_ls = {4{pwm_one_input}} & ~slam_ls_disable;
        next_lsp = ~next_ls;
        if (!slam_ok) begin
          next_state = HBBRK_ST_IDLE;
          next_ls = '0;
          next_lsp = 4'hf;
        end
      end
      HBBRK_ST_PARK: begin
        next_lsp = 4'h0;
        next_ls = {4{pwm_one_input}};
        if (!park_req) begin
          next_state = HBBRK_ST_IDLE;
          next_ls = '0;
          next_lsp = 4'hf;
        end
      end
      default: begin
        next_state = HBBRK_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state <= HBBRK_ST_IDLE;
      pcnt <= '0;
      act_q <= '0;
      hs_gate_on_q <= '0;
      ls_gate_on_q <= '0;
      hsp_q <= 4'hf;
      lsp_q <= 4'hf;
      pump_q <= 1'b0;
      brk_q <= 1'b0;
    end else begin
      state <= next_state;
      pcnt <= next_pcnt;
      act_q <= next_act;
      hs_gate_on_q <= next_hs;
      ls_gate_on_q <= next_ls;
      hsp_q <= next_hsp;
      lsp_q <= next_lsp;
      pump_q <= next_pump;
      brk_q <= next_brk;
    end
  end

  // Stage and level settings are registered so outputs come from flops.
  always_comb begin
    next_lvl = mosfet_level_select;
    next_stg = pump_auto_stage_select && supply_above_threshold;
    next_fcnt = fcnt + 16'h1;
    next_fclk = fclk_q;
    if (!pump_freq_mod_enable) begin
      next_fcnt = '0;
      next_fclk = 1'b0;
    end else if (fcnt >= 16'(HBBRK_FMOD_HALF_CYC - 1)) begin
      next_fcnt = '0;
      next_fclk = ~fclk_q;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      lvl_q <= HBBRK_MOSFET_LEVEL_SELECT_RST;
      stg_q <= HBBRK_AUTO_STAGE_RST;
      fcnt <= '0;
      fclk_q <= 1'b0;
    end else begin
      lvl_q <= next_lvl;
      stg_q <= next_stg;
      fcnt <= next_fcnt;
      fclk_q <= next_fclk;
    end
  end

  assign hs_gate_on = hs_gate_on_q;
  assign ls_gate_on = ls_gate_on_q;
  assign active_off = act_q;
  assign hs_passive_dis = hsp_q;
  assign ls_passive_dis = lsp_q;
  assign pump_on = pump_q;
  assign pump_normal_level = lvl_q;
  assign pump_single_stage = stg_q;
  assign pump_fmod_clk = fclk_q;
  assign brake_active = brk_q;

  AST_SLAM_NORMAL_ONLY: assert property (
    state == HBBRK_ST_SLAM |-> $past(in_normal))
    else $error("slam state outside normal mode");
  AST_OFF_MODES: assert property (
    (state == HBBRK_ST_IDLE && $past(state) == HBBRK_ST_IDLE &&
     $past(!in_normal) && $past(!park_req) && $past(!slam_ok))
    |-> (hs_passive_dis == 4'hf && ls_passive_dis == 4'hf &&
     hs_gate_on == '0 && ls_gate_on == '0))
    else $error("gates not held off outside normal mode");
  AST_PUMP_AFTER_ACTOFF: assert property (
    (state == HBBRK_ST_PUMPOFF) |-> !pump_on && active_off == '0)
    else $error("pump still on after active turn-off");
  AST_SLAM_ROUTE: assert property (
    (state == HBBRK_ST_SLAM && $past(state) == HBBRK_ST_SLAM && $past(slam_ok))
    |-> ls_gate_on == ($past(pwm_one_input) ? ~$past(slam_ls_disable) : 4'h0))
    else $error("slam low sides do not follow pwm input");
  AST_SLAM_TON: assert property (
    (state == HBBRK_ST_SLAM && slam_ok && pwm_one_input &&
     slam_ls_disable == '0) |-> ##[1:2] (ls_gate_on == 4'hf || !slam_ok))
    else $error("slam low sides late to turn on");
  AST_SLAM_DIS: assert property (
    ((ls_gate_on & $past(slam_ls_disable)) != '0) |->
    $past(state) != HBBRK_ST_SLAM)
    else $error("disabled low side driven in slam");
  sequence s_park_entry;
    state == HBBRK_ST_IDLE && park_req && !slam_ok;
  endsequence
  AST_PARK_ENTRY: assert property (
    s_park_entry |=> state == HBBRK_ST_ACTOFF)
    else $error("parking entry missed");
  AST_PARK_PASSIVE: assert property (
    (state == HBBRK_ST_PARK && $past(state) == HBBRK_ST_PARK &&
     $past(park_req)) |-> ls_passive_dis == '0 && hs_passive_dis == 4'hf
     && !pump_on)
    else $error("parking passive discharge wrong");
  AST_PARK_TON: assert property (
    (state == HBBRK_ST_PARK && park_req && pwm_one_input) |=>
    (ls_gate_on == 4'hf || !$past(park_req)))
    else $error("parking low sides not on");
  AST_LEVEL: assert property (
    ##1 pump_normal_level == $past(mosfet_level_select))
    else $error("level select not applied");
  AST_STAGE: assert property (
    !pump_auto_stage_select |=> !pump_single_stage)
    else $error("single stage without auto select");
  AST_FMOD_OFF: assert property (
    !pump_freq_mod_enable |=> !pump_fmod_clk)
    else $error("modulation running while disabled");
  AST_STEP_ORDER: assert property (
    (state == HBBRK_ST_ACTOFF && tmr_busy != '0) |=>
    state != HBBRK_ST_PUMPOFF)
    else $error("pump step before cross-current expiry");
endmodule : hbbrk_sequencer

// ===== testbench/hbbrk_bridge_model.sv
`timescale 1ns/10ps
module hbbrk_bridge_model (
  input wire logic ref_clk, // Clock.
  input wire logic pwm_cmd, // Level the controller puts on the pin.
  input wire logic [3:0] hs_gate_on, // High-side gates.
  input wire logic [3:0] ls_gate_on, // Low-side gates.
  output logic pwm_one_input, // Pin level seen by the block.
  output int shoot_count // Clock cycles with both switches of any leg on.
);
  initial shoot_count = 0;
  assign pwm_one_input = pwm_cmd;
  // Both switches of one leg on shorts the supply, so every cycle with any such leg counts once.
  always @(posedge ref_clk)
    if ((hs_gate_on & ls_gate_on) != 4'h0) shoot_count <= shoot_count + 1;
endmodule : hbbrk_bridge_model

// ===== testbench/halfbridge_brake_sequencer_tb_top.sv
`timescale 1ns/10ps
module halfbridge_brake_sequencer_tb_top;
  import hbbrk_pkg::*;
  typedef struct {string n; int s; logic [15:0] e;} hbbrk_note_t;
  logic ref_clk, sys_rst, slam_request, parking_brake_enable, pwm_cmd;
  logic [2:0] op_mode;
  logic [7:0] bridge_mode_field;
  logic [31:0] cross_current_protect_time;
  logic [3:0] slam_ls_disable, hs_normal, ls_normal, mask;
  logic pump_enable_bit, pwm_one_input, mosfet_level_select, v;
  logic pump_auto_stage_select, pump_freq_mod_enable, supply_above_threshold;
  logic [3:0] hs_gate_on, ls_gate_on, active_off, hs_passive_dis;
  logic [3:0] ls_passive_dis;
  logic pump_on, pump_normal_level, pump_single_stage, pump_fmod_clk;
  logic brake_active;
  logic [15:0] meas;
  int bad_count = 0, checks = 0, seed, shoot_count;
  hbbrk_note_t q[$];
  hbbrk_note_t t;
  event take;
  logic [2:0] offm [5] = '{HBBRK_OPM_INIT, HBBRK_OPM_STOP, HBBRK_OPM_SLEEP,
    HBBRK_OPM_FAILSAFE, HBBRK_OPM_RESTART};
  logic [2:0] parkm [2] = '{HBBRK_OPM_SLEEP, HBBRK_OPM_STOP};
  localparam int FMOD_HALF = 1000000000 / (50 * 15600 * 2);

  hbbrk_sequencer u_hbbrk_sequencer (.ref_clk, .sys_rst, .op_mode,
    .slam_request, .parking_brake_enable, .bridge_mode_field,
    .cross_current_protect_time, .slam_ls_disable, .pump_enable_bit,
    .pwm_one_input, .hs_normal, .ls_normal, .mosfet_level_select,
    .pump_auto_stage_select, .pump_freq_mod_enable, .supply_above_threshold,
    .hs_gate_on, .ls_gate_on, .active_off, .hs_passive_dis, .ls_passive_dis,
    .pump_on, .pump_normal_level, .pump_single_stage, .pump_fmod_clk,
    .brake_active);
  hbbrk_bridge_model u_hbbrk_bridge_model (.ref_clk, .pwm_cmd, .hs_gate_on,
    .ls_gate_on, .pwm_one_input, .shoot_count);

  initial begin
    ref_clk = 0;
    forever #25 ref_clk = ~ref_clk;
  end

  function automatic logic [15:0] seen(input int s);
    case (s)
      0: return {12'h0, active_off};
      1: return {12'h0, ls_gate_on};
      2: return {12'h0, hs_gate_on};
      3: return {12'h0, ls_passive_dis};
      4: return {12'h0, hs_passive_dis};
      5: return {12'h0, pump_on, pump_normal_level, pump_single_stage,
        brake_active};
      default: return meas;
    endcase
  endfunction : seen

  function automatic logic [3:0] act_mask(input logic [7:0] m);
    for (int g = 0; g < 4; g++)
      act_mask[g] = (m[2*g+:2] == 2'h1) || (m[2*g+:2] == 2'h2);
  endfunction : act_mask

  task check(input string n, input logic [15:0] s, input logic [15:0] e);
    checks++;
    if (s !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : check

  task note(input string n, input int s, input logic [15:0] e);
    q.push_back('{n, s, e});
    -> take;
  endtask : note

  task step(input int c);
    repeat (c) @(posedge ref_clk);
    #5;
  endtask : step

  task wait_brake;
    for (int i = 0; i < 10 && brake_active !== 1'b1; i++) step(1);
  endtask : wait_brake

  task close_out;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out

  // Results are sampled when the checker wakes, after the driving thread blocks, and notes drain in order.
  initial forever begin
    @(take);
    while (q.size() > 0) begin
      t = q.pop_front();
      check(t.n, seen(t.s), t.e);
    end
  end

  initial begin
    #(50 * 20000);
    bad_count++;
    close_out();
  end

  initial begin
    seed = 81;
    sys_rst = 1;
    {op_mode, slam_request, parking_brake_enable, pwm_cmd} = '0;
    {bridge_mode_field, cross_current_protect_time, slam_ls_disable} = '0;
    {pump_enable_bit, hs_normal, ls_normal, mosfet_level_select} = '0;
    {pump_auto_stage_select, supply_above_threshold} = '0;
    pump_freq_mod_enable = 1'b1;
    step(8);
    sys_rst = 0;
    step(1);
    note("rst_status", 5, 0);
    note("rst_ls_dis", 3, 'hf);
    note("rst_hs_dis", 4, 'hf);
    foreach (offm[i]) begin
      op_mode = offm[i];
      slam_request = 1;
      {hs_normal, ls_normal} = 8'hff;
      step(4);
      note("off_status", 5, 0);
      note("off_ls", 1, 0);
      note("off_hs", 2, 0);
      note("off_ls_dis", 3, 'hf);
    end
    slam_request = 0;
    // Normal gate requests stay set so that braking must override them.
    {hs_normal, ls_normal} = 8'h5a;
    op_mode = HBBRK_OPM_NORMAL;
    pump_enable_bit = 1;
    for (int k = 0; k < 8; k++) begin
      {mosfet_level_select, pump_auto_stage_select,
        supply_above_threshold} = k[2:0];
      step(3);
      note("pump_cfg", 5, {12'h0, 1'b1, k[2], k[1] & k[0], 1'b0});
    end
    {pump_auto_stage_select, supply_above_threshold} = '0;
    for (int r = 0; r < 4; r++) begin
      bridge_mode_field = 8'($random(seed));
      bridge_mode_field[1:0] = (r[0]) ? 2'h2 : 2'h1;
      cross_current_protect_time = ($random(seed) & 32'h07070707) |
        32'h01010101;
      slam_ls_disable = (r == 0) ? 4'h0 : 4'($random(seed));
      pwm_cmd = 1;
      mask = act_mask(bridge_mode_field);
      step(2);
      if (r < 2) slam_request = 1;
      else op_mode = parkm[r - 2];
      parking_brake_enable = (r >= 2);
      wait_brake();
      note("brk_act_off", 0, mask);
      note("brk_order", 5, {12'h0, 1'b1, mosfet_level_select, 2'b01});
      step(24);
      note("brk_pump", 5, {12'h0, 1'b0, mosfet_level_select, 2'b01});
      note("brk_hs", 2, 0);
      if (r < 2) begin
        note("slam_ls", 1, {12'h0, ~slam_ls_disable});
        pwm_cmd = 0;
        step(HBBRK_BRAKE_TON_CYC);
        note("slam_low", 1, 0);
        pwm_cmd = 1;
        step(HBBRK_BRAKE_TON_CYC);
        note("slam_high", 1, {12'h0, ~slam_ls_disable});
      end else begin
        note("park_ls_dis", 3, 0);
        note("park_hs_dis", 4, 'hf);
        note("park_ls", 1, 'hf);
      end
      {slam_request, parking_brake_enable} = '0;
      op_mode = HBBRK_OPM_NORMAL;
      step(6);
    end
    meas = 0;
    v = pump_fmod_clk;
    for (int i = 0; i < 1500 && pump_fmod_clk === v; i++) step(1);
    v = pump_fmod_clk;
    for (int i = 0; i < 1500 && pump_fmod_clk === v; i++) begin
      step(1);
      meas++;
    end
    note("fmod_half", 7, 16'(FMOD_HALF));
    pump_freq_mod_enable = 0;
    step(2);
    meas = 0;
    v = pump_fmod_clk;
    repeat (1400) begin
      step(1);
      if (pump_fmod_clk !== v) meas++;
      v = pump_fmod_clk;
    end
    note("fmod_off", 7, 0);
    // The checker reads meas when it runs, so let it drain before reuse.
    step(1);
    meas = shoot_count[15:0];
    note("cross_cond", 7, 0);
    step(2);
    close_out();
  end
endmodule : halfbridge_brake_sequencer_tb_top
